// ---- src/ldm_dot_scanner.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ldm_defs.vh"
module ldm_dot_scanner (
    input wire clk,
    input wire rst,
    input wire sfrWe,
    input wire [7:0] sfrAddr,
    input wire [7:0] sfrWdata,
    output reg [7:0] sfrRdata,
    input wire auxWe,
    input wire [7:0] auxAddr,
    input wire [7:0] auxWdata,
    output reg [7:0] auxRdata,
    input wire xWe,
    input wire [15:0] xAddr,
    input wire [7:0] xWdata,
    input wire frameIrqClr,
    output reg frameIrq,
    input wire [7:0] pinRouted,
    output reg [7:0] lampHigh,
    output reg [7:0] lampOe_n,
    output wire [3:0] lampCurrent,
    output wire scanBusy
);
    ////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 3'h0;
    localparam ST_LOAD = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_EVAL = 3'h3;
    localparam ST_ON = 3'h4;
    localparam ST_GAP = 3'h5;
    localparam ST_DONE = 3'h6;
    localparam ST_STOP = 3'h7;

    reg [7:0] runCtl_r;
    reg [7:0] dispCtl_r;
    reg [7:0] dispMode_r;
    reg [7:0] onTime1_r;
    reg [7:0] onTime2_r;
    reg [7:0] curReg_r;
    reg [2:0] state_r;
    reg [2:0] cathode_r;
    reg [2:0] anode_r;
    reg [2:0] phase_r;
    reg [7:0] litByte_r;
    reg [7:0] selByte_r;
    reg [7:0] tledDiv_r;
    reg [3:0] stepCnt_r;
    reg [8:0] unitCnt_r;
    reg [2:0] gapCnt_r;
    reg [8:0] groupLen_r;
    reg [5:0] lampA_r;
    reg [5:0] lampB_r;
    reg litA_r;
    reg litB_r;
    wire [7:0] memRdata;
    reg [`LDM_MEM_AW-1:0] memRaddr;
    wire memHit;
    wire scanOn;
    wire tledTick;
    wire [3:0] lines;
    wire [1:0] sizeCode;

    ////////////////////////////////////////////////////////////////////
    // dot matrix mode gate
    assign scanOn = runCtl_r[`LDM_RUN_BIT] & dispCtl_r[`LDM_DRVSEL_BIT]
        & dispMode_r[`LDM_LEDMOD_BIT] & ~dispCtl_r[`LDM_SINK_BIT];
    assign sizeCode = dispCtl_r[`LDM_SIZE_HI:`LDM_SIZE_LO];
    assign lines = `LDM_MIN_LINES + {2'b00, sizeCode};
    assign scanBusy = (state_r != ST_IDLE) && (state_r != ST_DONE)
        && (state_r != ST_STOP);
    assign lampCurrent = curReg_r[3:0];
    assign memHit = (xAddr >= `LDM_MEM_BASE) && (xAddr <= `LDM_MEM_LAST);

    ////////////////////////////////////////////////////////////////////
    // display memory
    ldm_display_mem uMem (
        .clk(clk),
        .memWe(xWe & memHit),
        .memWaddr(xAddr[`LDM_MEM_AW-1:0]),
        .memWdata(xWdata),
        .memRaddr(memRaddr),
        .memRdata(memRdata)
    );

    ////////////////////////////////////////////////////////////////////
    // register file
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            runCtl_r <= `LDM_REG_RST;
            dispCtl_r <= `LDM_REG_RST;
            dispMode_r <= `LDM_REG_RST;
            onTime1_r <= `LDM_REG_RST;
            onTime2_r <= `LDM_REG_RST;
            curReg_r <= `LDM_REG_RST;
        end
        else
        begin
            if (sfrWe)
            begin
                case (sfrAddr)
                    `LDM_ADR_RUN: runCtl_r <= {7'h00, sfrWdata[0]};
                    `LDM_ADR_CTRL: dispCtl_r <= {1'b0, sfrWdata[6:0]};
                    `LDM_ADR_MODE: dispMode_r <= sfrWdata;
                    `LDM_ADR_ON1: onTime1_r <= sfrWdata;
                    `LDM_ADR_ON2: onTime2_r <= sfrWdata;
                    default: runCtl_r <= runCtl_r;
                endcase
            end
            if (auxWe && auxAddr == `LDM_ADR_CUR)
            begin
                curReg_r <= auxWdata & `LDM_CUR_MASK;
            end
        end
    end

    always @*
    begin
        case (sfrAddr)
            `LDM_ADR_RUN: sfrRdata = runCtl_r;
            `LDM_ADR_CTRL: sfrRdata = dispCtl_r;
            `LDM_ADR_MODE: sfrRdata = dispMode_r;
            `LDM_ADR_ON1: sfrRdata = onTime1_r;
            `LDM_ADR_ON2: sfrRdata = onTime2_r;
            default: sfrRdata = 8'h00;
        endcase
        auxRdata = (auxAddr == `LDM_ADR_CUR) ? curReg_r : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // 1us lamp clock enable
    assign tledTick = (tledDiv_r == (`LDM_TLED_CYC - 1));
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tledDiv_r <= 8'h00;
        end
        // restart at group start so on-times are exact
        else if (!scanOn || tledTick || state_r == ST_EVAL)
        begin
            tledDiv_r <= 8'h00;
        end
        else
        begin
            tledDiv_r <= tledDiv_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // select byte read after each lit byte
    always @*
    begin
        memRaddr = {1'b0, phase_r[2] ? lampB_r[5:3] : lampA_r[5:3]};
        if (phase_r[0] || phase_r == 3'h6)
        begin
            memRaddr = memRaddr + `LDM_SEL_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // group: cathode line c, anode line a, pair lamps a*7+c / c*7+a-1
    wire [5:0] addrA;
    wire [5:0] addrB;
    assign addrA = {3'h0, anode_r} * 6'h07 + {3'h0, cathode_r}
        - ((cathode_r > anode_r) ? 6'h01 : 6'h00);
    assign addrB = {3'h0, cathode_r} * 6'h07 + {3'h0, anode_r}
        - ((anode_r > cathode_r) ? 6'h01 : 6'h00);

    wire selA;
    wire selB;
    assign selA = selByte_r[lampA_r[2:0]];
    assign selB = memRdata[lampB_r[2:0]];
    wire [7:0] tA;
    wire [7:0] tB;
    assign tA = selA ? onTime2_r : onTime1_r;
    assign tB = selB ? onTime2_r : onTime1_r;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            cathode_r <= 3'h0;
            anode_r <= 3'h1;
            phase_r <= 3'h0;
            litByte_r <= 8'h00;
            selByte_r <= 8'h00;
            stepCnt_r <= 4'h0;
            unitCnt_r <= 9'h000;
            gapCnt_r <= 3'h0;
            groupLen_r <= 9'h000;
            lampA_r <= 6'h00;
            lampB_r <= 6'h00;
            litA_r <= 1'b0;
            litB_r <= 1'b0;
            frameIrq <= 1'b0;
        end
        else
        begin
            // sticky flag, set wins over clear
            if (frameIrqClr)
            begin
                frameIrq <= 1'b0;
            end
            if (!scanOn)
            begin
                state_r <= ST_IDLE;
                cathode_r <= 3'h0;
                anode_r <= 3'h1;
                phase_r <= 3'h0;
                stepCnt_r <= 4'h0;
                unitCnt_r <= 9'h000;
                gapCnt_r <= 3'h0;
                litA_r <= 1'b0;
                litB_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        cathode_r <= 3'h0;
                        anode_r <= 3'h1;
                        phase_r <= 3'h0;
                        lampA_r <= 6'h01 * 6'h07;
                        lampB_r <= 6'h00;
                        state_r <= ST_LOAD;
                    end
                    ST_LOAD:
                    begin
                        lampA_r <= addrA;
                        lampB_r <= addrB;
                        phase_r <= 3'h0;
                        state_r <= ST_WAIT;
                    end
                    ST_WAIT:
                    begin
                        // reads: A lit, A sel, B lit, B sel
                        phase_r <= phase_r + 3'h1;
                        if (phase_r == 3'h1)
                        begin
                            litByte_r <= memRdata;
                        end
                        if (phase_r == 3'h2)
                        begin
                            selByte_r <= memRdata;
                        end
                        if (phase_r == 3'h5)
                        begin
                            litByte_r <= memRdata;
                            litA_r <= litByte_r[lampA_r[2:0]];
                        end
                        if (phase_r == 3'h6)
                        begin
                            litB_r <= litByte_r[lampB_r[2:0]];
                            state_r <= ST_EVAL;
                        end
                    end
                    ST_EVAL:
                    begin
                        if (litA_r && litB_r)
                        begin
                            groupLen_r <= (tA > tB) ? {1'b0, tA} : {1'b0, tB};
                        end
                        else
                        begin
                            groupLen_r <= litA_r ? {1'b0, tA} : {1'b0, tB};
                        end
                        stepCnt_r <= 4'h0;
                        unitCnt_r <= 9'h000;
                        state_r <= (litA_r || litB_r) ? ST_ON : ST_GAP;
                        gapCnt_r <= 3'h0;
                    end
                    ST_ON:
                    begin
                        if (tledTick)
                        begin
                            stepCnt_r <= stepCnt_r + 4'h1;
                            if (stepCnt_r == (`LDM_STEP_US - 1))
                            begin
                                unitCnt_r <= unitCnt_r + 9'h001;
                                if (unitCnt_r == groupLen_r)
                                begin
                                    state_r <= ST_GAP;
                                end
                            end
                        end
                    end
                    ST_GAP:
                    begin
                        // five lamp clocks per lit group
                        if (!(litA_r || litB_r) ||
                            (tledTick && gapCnt_r == (`LDM_GAP_TLED - 1)))
                        begin
                            litA_r <= 1'b0;
                            litB_r <= 1'b0;
                            state_r <= ST_LOAD;
                            if (anode_r == lines - 3'h1)
                            begin
                                anode_r <= 3'h0;
                                if (cathode_r == lines - 3'h2)
                                begin
                                    state_r <= ST_DONE;
                                end
                                else
                                begin
                                    cathode_r <= cathode_r + 3'h1;
                                    anode_r <= cathode_r + 3'h2;
                                end
                            end
                            else
                            begin
                                anode_r <= anode_r + 3'h1;
                            end
                        end
                        else if (tledTick)
                        begin
                            gapCnt_r <= gapCnt_r + 3'h1;
                        end
                    end
                    ST_DONE:
                    begin
                        if (dispCtl_r[`LDM_REPEAT_BIT])
                        begin
                            state_r <= ST_IDLE;
                        end
                        if (!dispCtl_r[`LDM_REPEAT_BIT])
                        begin
                            frameIrq <= 1'b1;
                            state_r <= ST_STOP;
                        end
                    end
                    ST_STOP:
                    begin
                        state_r <= ST_STOP;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // drive only lit lamps; only lines of the size
    integer i;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lampHigh <= 8'h00;
            lampOe_n <= 8'hff;
        end
        else
        begin
            lampHigh <= 8'h00;
            lampOe_n <= 8'hff;
            for (i = 0; i < 8; i = i + 1)
            begin
                if (state_r == ST_ON && dispCtl_r[`LDM_IOON_BIT]
                    && pinRouted[i] && i < lines)
                begin
                    if (i == cathode_r && litA_r)
                    begin
                        lampOe_n[i] <= 1'b0;
                    end
                    if (i == anode_r && litA_r)
                    begin
                        lampOe_n[i] <= 1'b0;
                        lampHigh[i] <= 1'b1;
                    end
                    if (i == anode_r && litB_r)
                    begin
                        lampOe_n[i] <= 1'b0;
                    end
                    if (i == cathode_r && litB_r)
                    begin
                        lampOe_n[i] <= 1'b0;
                        lampHigh[i] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // ldm_dot_scanner
`default_nettype wire

// ---- src/ldm_defs.vh ----
`ifndef LDM_DEFS_VH
`define LDM_DEFS_VH
// special function register addresses
`define LDM_ADR_RUN 8'haf
`define LDM_ADR_CTRL 8'hb1
`define LDM_ADR_MODE 8'hb2
`define LDM_ADR_ON1 8'hb3
`define LDM_ADR_ON2 8'hb4
// secondary bus address
`define LDM_ADR_CUR 8'h31
// display memory window
`define LDM_MEM_BASE 16'h1000
`define LDM_MEM_LAST 16'h100d
`define LDM_SEL_BASE 4'h7
`define LDM_MEM_AW 4
// reset value of all registers
`define LDM_REG_RST 8'h00
// field positions
`define LDM_RUN_BIT 0
`define LDM_IOON_BIT 6
`define LDM_SIZE_HI 4
`define LDM_SIZE_LO 3
`define LDM_DRVSEL_BIT 2
`define LDM_REPEAT_BIT 1
`define LDM_SINK_BIT 0
`define LDM_LEDMOD_BIT 7
`define LDM_CUR_MASK 8'h0f
// matrix sizes
`define LDM_SIZE_4X5 2'h0
`define LDM_SIZE_5X6 2'h1
`define LDM_SIZE_6X7 2'h2
`define LDM_SIZE_7X8 2'h3
`define LDM_MIN_LINES 4'h5
// timing
`define LDM_CLK_MHZ 40
`define LDM_TLED_NS 1000
`define LDM_TLED_CYC ((`LDM_TLED_NS * `LDM_CLK_MHZ) / 1000)
`define LDM_STEP_US 16
`define LDM_GAP_TLED 5
`endif

// ---- src/ldm_display_mem.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ldm_defs.vh"
module ldm_display_mem (
    input wire clk,
    input wire memWe,
    input wire [`LDM_MEM_AW-1:0] memWaddr,
    input wire [7:0] memWdata,
    input wire [`LDM_MEM_AW-1:0] memRaddr,
    output reg [7:0] memRdata
);
    reg [7:0] store [0:13];
    always @(posedge clk)
    begin
        if (memWe)
        begin
            store[memWaddr] <= memWdata;
        end
        memRdata <= store[memRaddr];
    end
endmodule // ldm_display_mem
`default_nettype wire

// ---- test/ldm_dot_scanner_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldm_dot_scanner_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfrWe,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic frameIrqClr,
    input wire logic frameIrq,
    input wire logic [7:0] pinRouted,
    input wire logic [7:0] lampHigh,
    input wire logic [7:0] lampOe_n,
    input wire logic scanBusy
);
    logic [7:0] ctrl_r;
    logic [7:0] mode_r;
    logic run_r;
    wire enOk = run_r & ctrl_r[6] & ctrl_r[2] & mode_r[7] & ~ctrl_r[0];
    wire [7:0] sizeMask = 8'hff >> (2'h3 - ctrl_r[4:3]);
    wire runWr = sfrWe && sfrAddr == 8'haf;
    ////////////////////////////////////////////////////////////////////
    // shadow of the control registers
    always @(posedge clk or posedge rst)
        if (rst)
        begin
            ctrl_r <= 8'h00;
            mode_r <= 8'h00;
            run_r <= 1'b0;
        end
        else if (sfrWe)
        begin
            if (sfrAddr == 8'hb1)
                ctrl_r <= sfrWdata;
            if (sfrAddr == 8'hb2)
                mode_r <= sfrWdata;
            if (sfrAddr == 8'haf)
                run_r <= sfrWdata[0];
        end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence runStop;
        runWr && !sfrWdata[0];
    endsequence
    sequence idleDark;
        !scanBusy ##1 lampOe_n == 8'hff;
    endsequence
    a_stop_clears_all: assert property (runStop |=> ##1 idleDark)
        else $error("stop did not clear scan state");
    a_dark_unless_on: assert property (!enOk && !$past(enOk) &&
        !$past(enOk, 2) |-> lampOe_n == 8'hff)
        else $error("lamp line driven while off");
    a_lines_in_size: assert property (scanBusy && $stable(ctrl_r) |->
        (~lampOe_n & ~sizeMask) == 8'h00) else $error("line outside size");
    a_routed_only: assert property ($stable(pinRouted) |->
        (~lampOe_n & ~pinRouted) == 8'h00) else $error("unrouted line");
    a_two_lamps_max: assert property (
        $countones(lampHigh & ~lampOe_n) <= 2) else $error("too many lit");
    a_irq_single_only: assert property ($rose(frameIrq) |->
        run_r && !ctrl_r[1]) else $error("flag outside single-shot");
    a_irq_sticky_flag: assert property (frameIrq && !frameIrqClr &&
        !runWr |=> frameIrq) else $error("flag dropped by itself");
    a_irq_at_end: assert property ($fell(scanBusy) && run_r &&
        !ctrl_r[1] |-> ##[0:2] frameIrq) else $error("no end flag");
    a_repeat_keeps_busy: assert property ($fell(scanBusy) && enOk &&
        ctrl_r[1] && !sfrWe |-> ##[1:2] scanBusy)
        else $error("repeat stopped");
endmodule // ldm_dot_scanner_properties
bind ldm_dot_scanner ldm_dot_scanner_properties ldm_dot_scanner_properties_inst (
    .clk(clk),
    .rst(rst),
    .sfrWe(sfrWe),
    .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata),
    .frameIrqClr(frameIrqClr),
    .frameIrq(frameIrq),
    .pinRouted(pinRouted),
    .lampHigh(lampHigh),
    .lampOe_n(lampOe_n),
    .scanBusy(scanBusy)
);
`default_nettype wire

// ---- test/ldm_lamp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldm_lamp_model (
    input wire logic [7:0] lampHigh,
    input wire logic [7:0] lampOe_n,
    output wire logic lampGlow
);
    wire [7:0] srcHigh = ~lampOe_n & lampHigh;
    wire [7:0] sinkLow = ~lampOe_n & ~lampHigh;
    assign lampGlow = (|srcHigh) && (|sinkLow);
endmodule // ldm_lamp_model
`default_nettype wire

// ---- test/test_ldm_dot_scanner.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ldm_defs.vh"
module test_ldm_dot_scanner;
    localparam int STEP = `LDM_STEP_US * `LDM_TLED_CYC;
    localparam int GAP = `LDM_GAP_TLED * `LDM_TLED_CYC;
    logic clk, rst, sfrWe, auxWe, xWe, frameIrqClr;
    logic [7:0] sfrAddr, sfrWdata, auxAddr, auxWdata, xWdata, pinRouted;
    logic [15:0] xAddr;
    logic [7:0] litB [0:6];
    logic [7:0] selB [0:6];
    logic [7:0] cfgC [0:3];
    logic [7:0] cfgP [0:3];
    logic [7:0] cfgM [0:3];
    wire [7:0] sfrRdata, auxRdata, lampHigh, lampOe_n;
    wire [3:0] lampCurrent;
    wire scanBusy, frameIrq, lampGlow;
    int fails, checks_done, busy, lit, f1;
    ldm_dot_scanner ldm_dot_scanner_inst (.clk(clk), .rst(rst),
        .sfrWe(sfrWe), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata), .auxWe(auxWe), .auxAddr(auxAddr),
        .auxWdata(auxWdata), .auxRdata(auxRdata), .xWe(xWe),
        .xAddr(xAddr), .xWdata(xWdata), .frameIrqClr(frameIrqClr),
        .frameIrq(frameIrq), .pinRouted(pinRouted), .lampHigh(lampHigh),
        .lampOe_n(lampOe_n), .lampCurrent(lampCurrent),
        .scanBusy(scanBusy));
    ldm_lamp_model ldm_lamp_model_inst (.lampHigh(lampHigh),
        .lampOe_n(lampOe_n), .lampGlow(lampGlow));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input int sel, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge clk);
        sfrWe <= (sel == 0);
        auxWe <= (sel == 1);
        xWe <= (sel == 2);
        sfrAddr <= a[7:0];
        auxAddr <= a[7:0];
        xAddr <= a;
        sfrWdata <= d;
        auxWdata <= d;
        xWdata <= d;
        @(posedge clk);
        sfrWe <= 1'b0;
        auxWe <= 1'b0;
        xWe <= 1'b0;
    endtask
    task automatic rd(input logic aux, input logic [7:0] a,
        input logic [7:0] e);
        @(posedge clk);
        sfrAddr <= a;
        auxAddr <= a;
        @(negedge clk);
        chk(aux ? auxRdata : sfrRdata, e);
    endtask
    task automatic put(input int i, input logic s);
        litB[i / 8][i % 8] = 1'b1;
        selB[i / 8][i % 8] = s;
    endtask
    task automatic wipe;
        for (int k = 0; k < 7; k++)
        begin
            litB[k] = 8'h00;
            selB[k] = 8'h00;
        end
    endtask
    task automatic load;
        for (int k = 0; k < 7; k++)
        begin
            wr(2, 16'h1000 + k, litB[k]);
            wr(2, 16'h1007 + k, selB[k]);
        end
    endtask
    task automatic frame;
        int n;
        busy = 0;
        lit = 0;
        n = 0;
        wr(0, 8'haf, 8'h01);
        while (frameIrq !== 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
            busy += scanBusy;
            lit += lampGlow;
        end
        chk(frameIrq, 1'b1);
        repeat (40) @(negedge clk) lit += lampGlow;
        chk(scanBusy, 1'b0);
        wr(0, 8'haf, 8'h00);
        wr(0, 8'haf, 8'h01);
        @(negedge clk);
        chk(frameIrq, 1'b1);
        @(posedge clk);
        frameIrqClr <= 1'b1;
        @(posedge clk);
        frameIrqClr <= 1'b0;
        @(negedge clk);
        chk(frameIrq, 1'b0);
        wr(0, 8'haf, 8'h00);
    endtask
    task automatic scan(input int n);
        lit = 0;
        wr(0, 8'haf, 8'h01);
        repeat (n) @(negedge clk) lit += lampGlow;
    endtask
    task automatic summarize;
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #1500000;
        fails++;
        summarize();
    end
    initial
    begin
        {rst, sfrWe, auxWe, xWe, frameIrqClr} = 5'h10;
        {sfrAddr, sfrWdata, auxAddr, auxWdata, xWdata} = 40'h0;
        xAddr = 16'h0000;
        pinRouted = 8'hff;
        fails = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(0, `LDM_ADR_RUN, 8'h00);
        rd(0, `LDM_ADR_CTRL, 8'h00);
        rd(0, `LDM_ADR_MODE, 8'h00);
        rd(0, `LDM_ADR_ON1, 8'h00);
        rd(0, `LDM_ADR_ON2, 8'h00);
        rd(1, `LDM_ADR_CUR, 8'h00);
        wr(0, `LDM_ADR_ON1, 8'h5a);
        rd(0, `LDM_ADR_ON1, 8'h5a);
        wr(0, 8'hb0, 8'h77);
        rd(0, 8'hb0, 8'h00);
        wr(1, `LDM_ADR_CUR, 8'hff);
        rd(1, `LDM_ADR_CUR, 8'h0f);
        chk(lampCurrent, 4'hf);
        wr(0, `LDM_ADR_ON1, 8'h00);
        wr(0, `LDM_ADR_MODE, 8'h80);
        wipe();
        put(0, 1'b0);
        load();
        for (int s = 0; s < 4; s++)
        begin
            wr(0, `LDM_ADR_CTRL, 8'h44 | (s << 3));
            frame();
            chk(lit, STEP);
            chk(busy >= STEP + GAP, 1);
        end
        f1 = busy;
        wipe();
        put(8, 1'b1);
        load();
        wr(0, `LDM_ADR_ON2, 8'h01);
        frame();
        chk(lit, 2 * STEP);
        chk(busy, f1 + STEP);
        wipe();
        put(0, 1'b0);
        put(7, 1'b1);
        load();
        wr(0, `LDM_ADR_ON2, 8'h02);
        frame();
        chk(busy, f1 + 2 * STEP);
        put(7, 1'b0);
        load();
        frame();
        chk(busy, f1);
        wipe();
        load();
        frame();
        chk(lit, 0);
        put(0, 1'b0);
        load();
        cfgC = '{8'h5c, 8'h1c, 8'h5d, 8'h5c};
        cfgP = '{8'h00, 8'hff, 8'hff, 8'hff};
        cfgM = '{8'h80, 8'h80, 8'h80, 8'h00};
        for (int k = 0; k < 4; k++)
        begin
            wr(0, `LDM_ADR_CTRL, cfgC[k]);
            wr(0, `LDM_ADR_MODE, cfgM[k]);
            pinRouted <= cfgP[k];
            scan(2000);
            chk(lit, 0);
            wr(0, 8'haf, 8'h00);
        end
        frameIrqClr <= 1'b1;
        @(posedge clk);
        frameIrqClr <= 1'b0;
        pinRouted <= 8'hff;
        wr(0, `LDM_ADR_MODE, 8'h80);
        wr(0, `LDM_ADR_CTRL, 8'h5e);
        scan(3 * f1);
        chk(lit >= 2 * STEP, 1);
        chk(frameIrq, 1'b0);
        wr(0, 8'haf, 8'h00);
        @(negedge clk);
        @(negedge clk);
        @(negedge clk);
        chk(scanBusy, 1'b0);
        chk(lampOe_n, 8'hff);
        summarize();
    end
endmodule // test_ldm_dot_scanner
`default_nettype wire
